// *** include/isr_bus_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface isr_bus_if;
	// Open-drain drivers of both ends; enable low while driving
	logic m_scl_o;
	logic m_scl_oe_n;
	logic m_sda_o;
	logic m_sda_oe_n;
	logic s_scl_o;
	logic s_scl_oe_n;
	logic s_sda_o;
	logic s_sda_oe_n;
	logic scl;
	logic sda;

	// Wired-AND line levels with pull-ups
	assign scl = (m_scl_oe_n | m_scl_o) & (s_scl_oe_n | s_scl_o);
	assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);

	modport master(output m_scl_o, output m_scl_oe_n, output m_sda_o, output m_sda_oe_n, input scl, input sda);
	modport slave(output s_scl_o, output s_scl_oe_n, output s_sda_o, output s_sda_oe_n, input scl, input sda);
endinterface
`default_nettype wire

// *** include/isr_pkg.sv ***
package isr_pkg;

	// ****************************************************
	// Timing
	// ****************************************************
	// System clock rate, used to turn times into cycles
	localparam int CLK_MHZ = 40;
	localparam int CNT_W = 9;
	// Host clock low time (least time, rounds up)
	localparam int T_HOST_LOW_NS = 4700;
	// Host clock high time (least time, rounds up)
	localparam int T_HOST_HIGH_NS = 4000;
	// Device own low period
	localparam int T_DEV_LOW_NS = 1300;
	localparam logic [CNT_W-1:0] HOST_LOW_CYC = CNT_W'((T_HOST_LOW_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] HOST_HIGH_CYC = CNT_W'((T_HOST_HIGH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] DEV_LOW_CYC = CNT_W'((T_DEV_LOW_NS * CLK_MHZ + 999) / 1000);
	// Repeated start and stop edges sit in the middle of a high period
	localparam logic [CNT_W-1:0] HALF_HIGH_CYC = CNT_W'((T_HOST_HIGH_NS * CLK_MHZ + 999) / 2000);

	// ****************************************************
	// Addressing
	// ****************************************************
	// Upper five bits of a ten-bit first address byte
	localparam logic [4:0] TEN_BIT_MARK = 5'h1E;
	localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
	localparam logic [7:0] SLAVE_ADDR_RST = 8'h00;
	localparam logic [7:0] RX_BUF_RST = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] ACK_SLOT = 4'h9;

	// ****************************************************
	// Host register map (APB)
	// ****************************************************
	localparam logic [7:0] CMD_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam int CMD_START_BIT = 8;
	localparam int CMD_STOP_BIT = 9;
	localparam int CMD_STOPONLY_BIT = 10;
	localparam logic [10:0] CMD_RST = 11'h000;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ACK_BIT = 1;
	localparam int STAT_WAIT_BIT = 2;

endpackage

// *** sim/i2c_slave_receiver_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module i2c_slave_receiver_test
	import isr_pkg::*;
;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err;
	logic en = 1'b0, ten = 1'b0, adr_wr = 1'b0, buf_rd = 1'b0, ovf_clr = 1'b0, irq_clr = 1'b0;
	logic [7:0] adr_data = 8'h00, rx_data, slave_addr;
	logic bf, ovf, irq, ua, rdir;
	int bad_count = 0, num_checks = 0, cyc = 0;

	// ****************************************************
	// Both ends joined on one bus
	// ****************************************************
	isr_bus_if isr_bus_if_i();
	isr_master_end isr_master_end_i(.I_SYS_CLK(sys_clk), .I_RESETN(resetn), .bus(isr_bus_if_i.master),
		.I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr));
	isr_slave_end isr_slave_end_i(.I_SYS_CLK(sys_clk), .I_RESETN(resetn), .bus(isr_bus_if_i.slave),
		.I_ENABLE(en), .I_TEN_BIT(ten), .I_ADDR_WR(adr_wr), .I_ADDR_DATA(adr_data), .I_BUF_RD(buf_rd),
		.I_OVF_CLR(ovf_clr), .I_IRQ_CLR(irq_clr), .O_RX_DATA(rx_data), .O_BUFFER_FULL(bf),
		.O_OVERFLOW(ovf), .O_IRQ_FLAG(irq), .O_ADDR_UPDATE(ua), .O_READ_DIR(rdir), .O_SLAVE_ADDR(slave_addr));
	isr_monitor isr_monitor_i(.I_SYS_CLK(sys_clk), .I_RESETN(resetn), .i_scl(isr_bus_if_i.scl),
		.i_sda(isr_bus_if_i.sda), .i_scl_oe_n(isr_bus_if_i.s_scl_oe_n), .i_sda_oe_n(isr_bus_if_i.s_sda_oe_n));

	// Clock and hang guard; run needs about 35k cycles
	initial forever #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			bad_count++;
			summarize();
		end
	end

	// ****************************************************
	// Access tasks
	// ****************************************************
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Setup, then access held until ready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One-cycle strobes {address write, buffer read, overflow clear, flag clear}
	task automatic user(input logic [3:0] s, input logic [7:0] d);
		@(posedge sys_clk);
		{adr_wr, buf_rd, ovf_clr, irq_clr} <= s;
		adr_data <= d;
		@(posedge sys_clk);
		{adr_wr, buf_rd, ovf_clr, irq_clr} <= 4'h0;
		@(negedge sys_clk);
	endtask

	// Command, then poll status until the host is no longer busy
	task automatic xfer(input logic [10:0] c);
		apb(1'b1, CMD_OFS, {21'h0, c});
		// A hang here is ended by the cycle guard, which counts it as a mismatch
		do begin
			apb(1'b0, STAT_OFS, 32'h0);
		end while (rd[STAT_BUSY_BIT] !== 1'b0);
		repeat (8) @(posedge sys_clk);
	endtask

	// Clear the flag first so that each byte must raise it anew
	task automatic byte_chk(input logic [10:0] c, input logic ak, input logic [7:0] rx, input logic [2:0] f);
		user(4'h1, 8'h00);
		xfer(c);
		`CHK("ack", ak, rd[STAT_ACK_BIT])
		`CHK("host waiting", ~c[CMD_STOP_BIT], rd[STAT_WAIT_BIT])
		`CHK("rx buffer", rx, rx_data)
		`CHK("bf ovf irq", f, {bf, ovf, irq})
	endtask

	// ****************************************************
	// Main sequence
	// ****************************************************
	initial begin
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		@(negedge sys_clk);
		`CHK("reset rx", RX_BUF_RST, rx_data)
		`CHK("reset addr", SLAVE_ADDR_RST, slave_addr)
		`CHK("reset flags", 5'h00, {bf, ovf, irq, ua, rdir})
		`CHK("pins released", 2'h3, {isr_bus_if_i.s_scl_oe_n, isr_bus_if_i.s_sda_oe_n})
		apb(1'b0, 8'h08, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0, rd)
		en <= 1'b1;
		user(4'h8, 8'hA4);
		`CHK("addr reg", 8'hA4, slave_addr)
		// Three full/overflow flag combinations in turn
		byte_chk(11'h1A4, 1'b1, 8'hA4, 3'h5);
		apb(1'b0, CMD_OFS, 32'h0);
		`CHK("cmd readback", 32'h0000_01A4, rd)
		byte_chk(11'h05A, 1'b0, 8'hA4, 3'h7);
		byte_chk(11'h033, 1'b0, 8'hA4, 3'h7);
		user(4'h4, 8'h00);
		`CHK("bf after read", 2'h1, {bf, ovf})
		byte_chk(11'h096, 1'b0, 8'hA4, 3'h3);
		user(4'h2, 8'h00);
		byte_chk(11'h2C3, 1'b1, 8'hC3, 3'h5);
		user(4'h4, 8'h00);
		// Wrong address and general call stay unanswered
		byte_chk(11'h1B6, 1'b0, 8'hC3, 3'h0);
		xfer(11'h400);
		user(4'h8, 8'h00);
		byte_chk(11'h300, 1'b0, 8'hC3, 3'h0);
		// Ten-bit sequence with address updates
		ten <= 1'b1;
		user(4'h8, 8'hF2);
		byte_chk(11'h1F2, 1'b1, 8'hF2, 3'h5);
		repeat (60) @(posedge sys_clk);
		`CHK("ua high byte", 1'b1, ua)
		`CHK("stretch", 1'b0, isr_bus_if_i.s_scl_oe_n)
		user(4'hC, 8'h5C);
		repeat (4) @(posedge sys_clk);
		`CHK("ua cleared", 1'b0, ua)
		`CHK("released", 1'b1, isr_bus_if_i.s_scl_oe_n)
		byte_chk(11'h05C, 1'b1, 8'h5C, 3'h5);
		`CHK("ua low byte", 1'b1, ua)
		user(4'hC, 8'hF2);
		`CHK("ua restored", 1'b0, ua)
		byte_chk(11'h1F3, 1'b1, 8'hF3, 3'h5);
		`CHK("read dir", 1'b1, rdir)
		user(4'h4, 8'h00);
		`CHK("bf read", 1'b0, bf)
		xfer(11'h400);
		summarize();
	end
endmodule
`default_nettype wire

// *** sim/isr_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module isr_monitor
	import isr_pkg::*;
(
	input wire logic I_SYS_CLK,
	input wire logic I_RESETN,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_scl_oe_n,
	input wire logic i_sda_oe_n
);
	int low_cnt;
	int high_cnt;
	int hold_cnt;

	// Run lengths of the line levels and of the device hold
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			low_cnt <= 0;
			high_cnt <= 0;
			hold_cnt <= 0;
		end else begin
			low_cnt <= i_scl ? 0 : low_cnt + 1;
			high_cnt <= i_scl ? high_cnt + 1 : 0;
			hold_cnt <= i_scl_oe_n ? 0 : hold_cnt + 1;
		end
	end

	// ****************************************************
	// Line checks
	// ****************************************************
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RESETN);

	// Data falls while clock stays high
	sequence start_seen;
		$fell(i_sda) && i_scl && $past(i_scl);
	endsequence
	// Acknowledge kept low across the ninth rise
	sequence ack_slot;
		!i_sda_oe_n throughout (##[1:300] $rose(i_scl));
	endsequence

	chk_hold_in_low: assert property ($fell(i_scl_oe_n) |-> !i_scl)
		else $error("device pulled clock while line high");
	chk_hold_length: assert property ($rose(i_scl_oe_n) |-> hold_cnt >= DEV_LOW_CYC - 1)
		else $error("device clock hold too short");
	chk_low_time: assert property ($rose(i_scl) |-> low_cnt >= HOST_LOW_CYC - 1)
		else $error("clock low period too short");
	chk_high_time: assert property ($fell(i_scl) |-> high_cnt >= HOST_HIGH_CYC - 1)
		else $error("clock high period too short");
	chk_data_in_low: assert property ($changed(i_sda_oe_n) |-> !i_scl)
		else $error("device moved data while clock high");
	chk_ack_held: assert property ($fell(i_sda_oe_n) |-> ack_slot)
		else $error("acknowledge dropped before ninth rise");
	chk_ack_release: assert property ($fell(i_sda_oe_n) |-> ##[1:700] $rose(i_sda_oe_n))
		else $error("acknowledge not released");
	chk_start_clock: assert property (start_seen |-> ##[1:200] $fell(i_scl))
		else $error("no clock after start");
	chk_stop_idle: assert property ($rose(i_sda) && i_scl && $past(i_scl) |-> (i_scl && i_sda) [*8])
		else $error("lines not idle after stop");
endmodule
`default_nettype wire

// *** verilog/isr_clk_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module isr_clk_sync
	import isr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_gen,
	input wire logic [CNT_W-1:0] i_low_cyc,
	input wire logic [CNT_W-1:0] i_high_cyc,
	output logic o_hold
);
	logic scl_d;
	logic [CNT_W-1:0] cnt;

	// Previous line level for fall detection
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_d <= 1'h1;
		end else begin
			scl_d <= i_scl;
		end
	end

	// Low and high period counting on the shared clock line
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_hold <= 1'h0;
			cnt <= '0;
		end else if (scl_d && !i_scl) begin
			o_hold <= 1'h1;
			cnt <= '0;
		end else if (o_hold) begin
			if (cnt >= CNT_W'(i_low_cyc - 1'h1)) begin
				o_hold <= 1'h0;
				cnt <= '0;
			end else begin
				cnt <= CNT_W'(cnt + 1'h1);
			end
		end else if (!i_scl) begin
			cnt <= '0;
		end else if (i_gen) begin
			// Line is high: count the high period together with the others
			if (cnt >= CNT_W'(i_high_cyc - 1'h1)) begin
				o_hold <= 1'h1;
				cnt <= '0;
			end else begin
				cnt <= CNT_W'(cnt + 1'h1);
			end
		end else begin
			cnt <= '0;
		end
	end
endmodule
`default_nettype wire

// *** verilog/isr_master_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module isr_master_end
	import isr_pkg::*;
(
	input wire logic I_SYS_CLK,
	input wire logic I_RESETN,
	isr_bus_if.master bus,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR
);
	typedef enum logic [2:0] {H_IDLE, H_BYTE, H_WAIT, H_RSTART, H_STOP} isr_hst_t;

	isr_hst_t state;
	logic scl_m, scl_s, scl_p;
	logic sda_m, sda_s;
	logic [10:0] cmd;
	logic [7:0] tx;
	logic [3:0] bitn;
	logic sda_low;
	logic gen;
	logic wait_hold;
	logic acked;
	logic stop_after;
	logic [CNT_W-1:0] hcnt;
	logic sync_hold;

	// ****************************************************
	// APB slave
	// ****************************************************
	logic cmd_wr, can_take, mapped, busy;
	assign mapped = (I_PADDR == CMD_OFS) || (I_PADDR == STAT_OFS);
	assign can_take = (state == H_IDLE) || (state == H_WAIT);
	// Commands while a byte is moving are dropped
	assign cmd_wr = I_PSEL && I_PENABLE && I_PWRITE && (I_PADDR == CMD_OFS) && can_take;
	assign busy = !can_take;
	assign O_PREADY = 1'h1;
	assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;

	// Read data captured in the setup cycle, stable through access
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_PRDATA <= 32'h0000_0000;
		end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
			if (I_PADDR == CMD_OFS) begin
				O_PRDATA <= {21'h000000, cmd};
			end else if (I_PADDR == STAT_OFS) begin
				O_PRDATA <= {29'h00000000, state == H_WAIT, acked, busy};
			end else begin
				O_PRDATA <= 32'h0000_0000;
			end
		end
	end

	// Last accepted command, kept for read-back
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			cmd <= CMD_RST;
		end else if (cmd_wr) begin
			cmd <= I_PWDATA[10:0];
		end
	end

	// ****************************************************
	// Line sampling
	// ****************************************************
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			scl_m <= 1'h1;
			scl_s <= 1'h1;
			scl_p <= 1'h1;
			sda_m <= 1'h1;
			sda_s <= 1'h1;
		end else begin
			scl_m <= bus.scl;
			scl_s <= scl_m;
			scl_p <= scl_s;
			sda_m <= bus.sda;
			sda_s <= sda_m;
		end
	end

	logic scl_rise, scl_fall;
	assign scl_rise = scl_s & ~scl_p;
	assign scl_fall = scl_p & ~scl_s;

	// ****************************************************
	// Byte engine
	// ****************************************************
	// Data changes on observed clock falls or on a command in the idle or wait state; repeated start and stop mid-high
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			state <= H_IDLE;
			tx <= 8'h00;
			bitn <= 4'h0;
			sda_low <= 1'h0;
			gen <= 1'h0;
			wait_hold <= 1'h0;
			stop_after <= 1'h0;
			hcnt <= '0;
		end else begin
			case (state)
				H_IDLE: begin
					if (cmd_wr && I_PWDATA[CMD_START_BIT]) begin
						sda_low <= 1'h1;
						gen <= 1'h1;
						tx <= I_PWDATA[7:0];
						stop_after <= I_PWDATA[CMD_STOP_BIT];
						bitn <= 4'h0;
						state <= H_BYTE;
					end
				end
				H_BYTE: begin
					// Clock leaves the wait hold one cycle after the data line has settled
					wait_hold <= 1'h0;
					if (scl_fall) begin
						if (bitn < BITS_PER_BYTE) begin
							sda_low <= ~tx[7];
							tx <= {tx[6:0], 1'h0};
							bitn <= 4'(bitn + 1'h1);
						end else if (bitn == BITS_PER_BYTE) begin
							sda_low <= 1'h0;
							bitn <= ACK_SLOT;
						end else if (stop_after) begin
							sda_low <= 1'h1;
							gen <= 1'h0;
							hcnt <= '0;
							state <= H_STOP;
						end else begin
							// Hold the clock low until software gives the next order
							wait_hold <= 1'h1;
							gen <= 1'h0;
							state <= H_WAIT;
						end
					end
				end
				H_WAIT: begin
					if (cmd_wr) begin
						stop_after <= I_PWDATA[CMD_STOP_BIT];
						tx <= I_PWDATA[7:0];
						hcnt <= '0;
						// Data moves first; the next state lets the clock go a cycle later
						if (I_PWDATA[CMD_START_BIT]) begin
							sda_low <= 1'h0;
							gen <= 1'h1;
							state <= H_RSTART;
						end else if (I_PWDATA[CMD_STOPONLY_BIT]) begin
							sda_low <= 1'h1;
							state <= H_STOP;
						end else begin
							sda_low <= ~I_PWDATA[7];
							tx <= {I_PWDATA[6:0], 1'h0};
							bitn <= 4'h1;
							gen <= 1'h1;
							state <= H_BYTE;
						end
					end
				end
				H_RSTART, H_STOP: begin
					wait_hold <= 1'h0;
					// Second data edge half way into the clock high period
					if (!scl_s) begin
						hcnt <= '0;
					end else if (hcnt >= HALF_HIGH_CYC) begin
						bitn <= 4'h0;
						sda_low <= (state == H_RSTART);
						state <= (state == H_RSTART) ? H_BYTE : H_IDLE;
					end else begin
						hcnt <= CNT_W'(hcnt + 1'h1);
					end
				end
				default: begin
					state <= H_IDLE;
				end
			endcase
		end
	end

	// Acknowledge sampled on the rise of the ninth clock
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			acked <= 1'h0;
		end else if (state == H_BYTE && scl_rise && bitn == ACK_SLOT) begin
			acked <= ~sda_s;
		end
	end

	// Clock generator takes part in synchronisation like any other end
	isr_clk_sync u_sync (
		.i_clk(I_SYS_CLK),
		.i_rst_n(I_RESETN),
		.i_scl(scl_s),
		.i_gen(gen),
		.i_low_cyc(HOST_LOW_CYC),
		.i_high_cyc(HOST_HIGH_CYC),
		.o_hold(sync_hold)
	);

	assign bus.m_scl_o = 1'h0;
	assign bus.m_sda_o = 1'h0;
	assign bus.m_scl_oe_n = ~(sync_hold | wait_hold);
	assign bus.m_sda_oe_n = ~sda_low;
endmodule
`default_nettype wire

// *** verilog/isr_slave_end.sv ***
// Overview of operation
// - Pulled clock stays low until low count ends
// - Restart low count on every clock fall
// - Early finisher releases, waits for line high
// - First finished high count pulls clock low; the device itself counts no high period
// - Pins idle released; driven only when needed
// - Matched byte: acknowledge and load buffer at once
// - Full or overflow: no acknowledge, no load
// - Interrupt flag set on every address-matched byte
// - Buffer read clears full; overflow cleared by software
// - After enable, await start, shift eight bits
// - Sample data on clock rising edge
// - Compare address bits at eighth falling edge
// - Match: load, full, acknowledge, interrupt at ninth
// - Ten-bit first byte pattern with write bit
// - High byte sets update; address write releases
// - Low byte sets update; high byte restored
// - Repeated start read high byte sets flags
// - No general call recognition
// - Start and stop are data edges, clock high
`timescale 1ns/1ps
`default_nettype none
module isr_slave_end
	import isr_pkg::*;
(
	input wire logic I_SYS_CLK,
	input wire logic I_RESETN,
	isr_bus_if.slave bus,
	input wire logic I_ENABLE,
	input wire logic I_TEN_BIT,
	input wire logic I_ADDR_WR,
	input wire logic [7:0] I_ADDR_DATA,
	input wire logic I_BUF_RD,
	input wire logic I_OVF_CLR,
	input wire logic I_IRQ_CLR,
	output logic [7:0] O_RX_DATA,
	output logic O_BUFFER_FULL,
	output logic O_OVERFLOW,
	output logic O_IRQ_FLAG,
	output logic O_ADDR_UPDATE,
	output logic O_READ_DIR,
	output logic [7:0] O_SLAVE_ADDR
);
	typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_ACK} isr_st_t;
	typedef enum logic [1:0] {PH_ADDR, PH_LOW, PH_DATA} isr_ph_t;

	isr_st_t state;
	isr_ph_t phase;
	logic scl_m, scl_s, scl_p;
	logic sda_m, sda_s, sda_p;
	logic [7:0] serial_shift_register;
	logic [3:0] bit_cnt;
	logic ack_drive;
	logic stretch;
	logic ten_ok;
	logic end_after_ack;
	logic sync_hold;

	// ****************************************************
	// Line sampling
	// ****************************************************
	// Three flops on each pin; the first is read by the second only
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			scl_m <= 1'h1;
			scl_s <= 1'h1;
			scl_p <= 1'h1;
			sda_m <= 1'h1;
			sda_s <= 1'h1;
			sda_p <= 1'h1;
		end else begin
			scl_m <= bus.scl;
			scl_s <= scl_m;
			scl_p <= scl_s;
			sda_m <= bus.sda;
			sda_s <= sda_m;
			sda_p <= sda_s;
		end
	end

	// Edge and condition detection on the synchronised levels
	logic scl_rise, scl_fall, start_det, stop_det;
	assign scl_rise = scl_s & ~scl_p;
	assign scl_fall = scl_p & ~scl_s;
	assign start_det = scl_s & scl_p & sda_p & ~sda_s;
	assign stop_det = scl_s & scl_p & ~sda_p & sda_s;

	// ****************************************************
	// Address decision
	// ****************************************************
	// Decision is taken at the falling edge closing the eighth bit
	logic at_eighth, at_ninth, hit, ok, ua_evt, ten_evt, rd_evt;
	logic hi_ok, seven_ok;
	assign at_eighth = (state == ST_RECV) && scl_fall && (bit_cnt == BITS_PER_BYTE);
	assign at_ninth = (state == ST_ACK) && scl_fall;
	assign hi_ok = (serial_shift_register[7:3] == TEN_BIT_MARK)
		&& (serial_shift_register[7:1] == O_SLAVE_ADDR[7:1]);
	// General call is not recognised, whatever the address register holds
	assign seven_ok = (serial_shift_register[7:1] == O_SLAVE_ADDR[7:1])
		&& (serial_shift_register[7:1] != GEN_CALL_ADDR);
	assign ok = !O_BUFFER_FULL && !O_OVERFLOW;

	always_comb begin
		hit = 1'h0;
		ua_evt = 1'h0;
		ten_evt = 1'h0;
		rd_evt = 1'h0;
		case (phase)
			PH_ADDR: begin
				if (I_TEN_BIT) begin
					// Write bit leads on to the low byte; read needs an earlier full match
					if (hi_ok && !serial_shift_register[0]) begin
						hit = 1'h1;
						ua_evt = 1'h1;
					end else if (hi_ok && serial_shift_register[0] && ten_ok) begin
						hit = 1'h1;
						rd_evt = 1'h1;
					end
				end else if (seven_ok) begin
					hit = 1'h1;
					rd_evt = serial_shift_register[0];
				end
			end
			PH_LOW: begin
				if (serial_shift_register == O_SLAVE_ADDR) begin
					hit = 1'h1;
					ua_evt = 1'h1;
					ten_evt = 1'h1;
				end
			end
			PH_DATA: begin
				hit = 1'h1;
			end
			default: begin
				hit = 1'h0;
			end
		endcase
	end

	logic load_evt;
	assign load_evt = at_eighth && hit && ok;

	// ****************************************************
	// Byte engine
	// ****************************************************
	// Start restarts from any state; stop or disable returns to idle
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			state <= ST_IDLE;
			phase <= PH_ADDR;
			bit_cnt <= 4'h0;
			ack_drive <= 1'h0;
			ten_ok <= 1'h0;
			end_after_ack <= 1'h0;
		end else if (!I_ENABLE || stop_det) begin
			state <= ST_IDLE;
			ack_drive <= 1'h0;
			ten_ok <= 1'h0;
		end else if (start_det) begin
			state <= ST_RECV;
			phase <= PH_ADDR;
			bit_cnt <= 4'h0;
			ack_drive <= 1'h0;
		end else begin
			case (state)
				ST_RECV: begin
					if (scl_rise && bit_cnt < BITS_PER_BYTE) begin
						bit_cnt <= 4'(bit_cnt + 1'h1);
					end else if (at_eighth) begin
						if (hit) begin
							state <= ST_ACK;
							bit_cnt <= ACK_SLOT;
							ack_drive <= ok;
							end_after_ack <= rd_evt;
							if (ua_evt && phase == PH_ADDR) begin
								phase <= PH_LOW;
							end else begin
								phase <= PH_DATA;
							end
							if (ten_evt) begin
								ten_ok <= 1'h1;
							end
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				ST_ACK: begin
					if (at_ninth) begin
						ack_drive <= 1'h0;
						bit_cnt <= 4'h0;
						// Transmit side is not built: a read ends the frame here
						state <= end_after_ack ? ST_IDLE : ST_RECV;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Shift register takes the data line on each of the eight bit rising clock edges while receiving
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			serial_shift_register <= 8'h00;
		end else if (state == ST_RECV && scl_rise && bit_cnt < BITS_PER_BYTE) begin
			serial_shift_register <= {serial_shift_register[6:0], sda_s};
		end
	end

	// ****************************************************
	// Buffer and flags
	// ****************************************************
	// Receive buffer loads only from an accepted byte
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_RX_DATA <= RX_BUF_RST;
			O_READ_DIR <= 1'h0;
		end else if (load_evt) begin
			O_RX_DATA <= serial_shift_register;
			O_READ_DIR <= rd_evt;
		end
	end

	// Set wins over clear on every flag, so no event is lost
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_BUFFER_FULL <= 1'h0;
		end else if (load_evt) begin
			O_BUFFER_FULL <= 1'h1;
		end else if (I_BUF_RD) begin
			O_BUFFER_FULL <= 1'h0;
		end
	end

	// Overflow marks a byte lost while the buffer was still held
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_OVERFLOW <= 1'h0;
		end else if (at_eighth && hit && !ok) begin
			O_OVERFLOW <= 1'h1;
		end else if (I_OVF_CLR) begin
			O_OVERFLOW <= 1'h0;
		end
	end

	// Interrupt at the falling edge of the ninth pulse, accepted or not
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_IRQ_FLAG <= 1'h0;
		end else if (at_ninth) begin
			O_IRQ_FLAG <= 1'h1;
		end else if (I_IRQ_CLR) begin
			O_IRQ_FLAG <= 1'h0;
		end
	end

	// Update flag and address register; a write clears the flag
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_ADDR_UPDATE <= 1'h0;
			O_SLAVE_ADDR <= SLAVE_ADDR_RST;
		end else begin
			if (I_ADDR_WR) begin
				O_SLAVE_ADDR <= I_ADDR_DATA;
			end
			if (at_eighth && ua_evt) begin
				O_ADDR_UPDATE <= 1'h1;
			end else if (I_ADDR_WR) begin
				O_ADDR_UPDATE <= 1'h0;
			end
		end
	end

	// Stretch starts after the acknowledge clock so the master sees it
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			stretch <= 1'h0;
		end else if (!O_ADDR_UPDATE || !I_ENABLE) begin
			stretch <= 1'h0;
		end else if (at_ninth) begin
			stretch <= 1'h1;
		end
	end

	// ****************************************************
	// Clock participation and pin drive
	// ****************************************************
	// Device never generates a high period, only its own low one
	isr_clk_sync u_sync (
		.i_clk(I_SYS_CLK),
		.i_rst_n(I_RESETN),
		.i_scl(scl_s),
		.i_gen(1'h0),
		.i_low_cyc(DEV_LOW_CYC),
		.i_high_cyc(HOST_HIGH_CYC),
		.o_hold(sync_hold)
	);

	// Open drain: lines released unless holding or acknowledging
	assign bus.s_scl_o = 1'h0;
	assign bus.s_sda_o = 1'h0;
	assign bus.s_scl_oe_n = ~((sync_hold & I_ENABLE) | stretch);
	assign bus.s_sda_oe_n = ~ack_drive;
endmodule
`default_nettype wire
